//--- common/cfgbank_pkg.sv
// Constants for the video converter and clock synthesizer configuration bank
package cfgbank_pkg;
    typedef logic [7:0] reg_byte_t;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_VADC0_POWER_SELECT = 8'h80;
    localparam logic [7:0] IDX_VADC0_BIAS_CHROMA_CLAMP = 8'h81;
    localparam logic [7:0] IDX_VADC0_GAIN_PAIR1 = 8'h82;
    localparam logic [7:0] IDX_VADC0_GAIN_PAIR2 = 8'h83;
    localparam logic [7:0] IDX_VADC0_CLAMP_PAIR1 = 8'h84;
    localparam logic [7:0] IDX_VADC0_CLAMP_PAIR2 = 8'h85;
    localparam logic [7:0] IDX_VADC1_POWER_SELECT = 8'h86;
    localparam logic [7:0] IDX_VADC1_BIAS_CHROMA_CLAMP = 8'h87;
    localparam logic [7:0] IDX_VADC1_GAIN_PAIR3 = 8'h88;
    localparam logic [7:0] IDX_VADC1_GAIN_PAIR4 = 8'h89;
    localparam logic [7:0] IDX_VADC1_CLAMP_PAIR3 = 8'h8a;
    localparam logic [7:0] IDX_VADC1_CLAMP_PAIR4 = 8'h8b;
    localparam logic [7:0] IDX_VADC_FILTER_SELECT = 8'h8c;
    localparam logic [7:0] IDX_VADC_CLOCK_DELAY_A = 8'h8d;
    localparam logic [7:0] IDX_VADC_CLOCK_DELAY_B = 8'h8e;
    localparam logic [7:0] IDX_DECODER_CLOCK_DELAY = 8'h8f;
    localparam logic [7:0] IDX_PLL_OVERRIDE_CONTROL = 8'h90;
    localparam logic [7:0] IDX_PLL_PIN_CONTROLS = 8'h91;
    localparam logic [7:0] IDX_PLL1_MULTIPLIER_LOW = 8'h92;
    localparam logic [7:0] IDX_PLL1_DIVIDER_MULT_HIGH = 8'h93;
    localparam logic [7:0] IDX_PLL2_MULTIPLIER_LOW = 8'h94;
    localparam logic [7:0] IDX_PLL2_DIVIDER_MULT_HIGH = 8'h95;
    localparam logic [7:0] IDX_PLL_OUTPUT_DIVIDERS = 8'h96;
    localparam int NUM_REGS = 23;

    // Slots relative to the bank's first register; power select, bias, gain and clamp repeat in each converter group
    localparam int CONV_STRIDE = 6;
    localparam int SLOT_BIAS = 1;
    localparam int SLOT_GAIN = 2;
    localparam int SLOT_CLAMP = 4;
    localparam int SLOT_LPF = 12;
    localparam int SLOT_DLY_A = 13;
    localparam int SLOT_DLY_B = 14;
    localparam int SLOT_DLY_VD = 15;
    localparam int SLOT_PLL_CTRL = 16;
    localparam int SLOT_PLL_PINS = 17;
    localparam int SLOT_PLL1_M = 18;
    localparam int SLOT_PLL_OD = 22;

    // Field positions
    localparam int POS_PAIR_PD = 0;
    localparam int POS_MANUAL_GAIN = 2;
    localparam int POS_INPUT_SEL = 4;
    localparam int POS_BIAS = 4;
    localparam int POS_PLL_BP = 0;
    localparam int POS_PLL_PD = 1;
    localparam int POS_PLL_OE = 4;
    localparam int POS_PLL_RST = 7;
    localparam int POS_M_HIGH = 7;
    localparam int POS_PLL_OD = 4;
    localparam int WID_N = 5;
    localparam int WID_M = 9;
    localparam int WID_OD = 4;

    localparam reg_byte_t REG_RESET [NUM_REGS] = '{
        8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam reg_byte_t REG_MASK [NUM_REGS] = '{
        8'h57, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h57, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h0f, 8'h77, 8'h77, 8'h07,
        8'h03, 8'h3f, 8'hff, 8'h9f, 8'hff, 8'h9f, 8'hff};
    // Synthesizer configuration survives the settle reset
    localparam logic [NUM_REGS-1:0] REG_KEEP = 23'h7f0000;

    // Filter select codes
    localparam logic [1:0] LPF_6MHZ = 2'h0;
    localparam logic [1:0] LPF_9MHZ = 2'h1;

    // Clock delay: one step per code
    localparam int CLK_DELAY_STEP_PS = 600;

    // Synthesizer source codes
    localparam logic [1:0] CLKSRC_OFF = 2'h0;
    localparam logic [1:0] CLKSRC_XIN = 2'h1;
    localparam logic [1:0] CLKSRC_SYNTH = 2'h2;
    localparam logic [1:0] CLKSRC_UNDEF = 2'h3;

    // Hard-wired defaults: 144 MHz and 74.25 MHz from a 27 MHz reference
    localparam logic [8:0] PLL1_DEF_M = 9'h03e;
    localparam logic [4:0] PLL1_DEF_N = 5'h04;
    localparam logic [3:0] PLL1_DEF_OD = 4'h1;
    localparam logic [8:0] PLL2_DEF_M = 9'h014;
    localparam logic [4:0] PLL2_DEF_N = 5'h00;
    localparam logic [3:0] PLL2_DEF_OD = 4'h2;

    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int PLL_SETTLE_US = 1000;
    localparam int PLL_SETTLE_CYCLES = (CLK_HZ / 1_000_000) * PLL_SETTLE_US;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SETTLE = 2'b10
    } seq_state_e;
endpackage

//--- core/video_adc_pll_config_bank.sv
// Configuration bank for two dual-input video converters and two clock synthesizers
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ns
module video_adc_pll_config_bank
    import cfgbank_pkg::*;
#(
    parameter int SETTLE_CYCLES = PLL_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Hardware automatic gain, one nibble per input, 1A first
    input wire logic [31:0] auto_gain,
    // Converter front end controls, index 0 is pair 1
    output logic [3:0] input_a_power_down,
    output logic [3:0] input_b_power_down,
    output logic [3:0] pair_input_select,
    output logic [1:0] conv_manual_gain_sel,
    output logic [31:0] input_gain_value,
    output logic [7:0] input_chroma_clamp,
    output logic [31:0] input_clamp_value,
    output logic [7:0] conv_bias_setting,
    // Filter selects, index 0 is converter 0
    output logic [1:0] lpf_6mhz_en,
    output logic [1:0] lpf_9mhz_en,
    output logic [1:0] lpf_bypass,
    // Delay codes: conv0, conv1, 36 MHz, 72 MHz, decoder
    output logic [14:0] clock_delay_sel,
    // Synthesizer settings, index 0 is the first one
    output logic [17:0] pll_multiplier,
    output logic [9:0] pll_predivider,
    output logic [7:0] pll_output_divider,
    output logic [1:0] pll_powerdown,
    output logic [1:0] pll_bypass,
    output logic [1:0] pll_output_enable_n,
    output logic [3:0] pll_clock_source,
    // Chip held in reset while the synthesizers settle
    output logic settle_reset
);
    reg_byte_t regs_q [NUM_REGS];
    seq_state_e state_q;
    logic [31:0] cnt_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] idx;
    logic hit;
    logic [4:0] slot;
    logic req;
    logic wr;
    logic rst_req;
    logic busy;
    reg_byte_t rd_byte;

    assign idx = wb_adr_i[9:2];
    assign hit = (idx >= IDX_VADC0_POWER_SELECT) && (idx <= IDX_PLL_OUTPUT_DIVIDERS);
    assign slot = 5'(idx - IDX_VADC0_POWER_SELECT);
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i && wb_sel_i[0] && hit;
    assign rst_req = wr && (idx == IDX_PLL_OVERRIDE_CONTROL) && wb_dat_i[POS_PLL_RST];
    assign busy = (state_q == ST_SETTLE);

    // Answer one cycle after the request, drop the cycle after
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (hit) begin
            rd_byte = regs_q[slot];
            if (32'(slot) == SLOT_PLL_CTRL) begin
                rd_byte[POS_PLL_RST] = busy;
            end
        end
    end

    // Unmapped addresses answer with zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (req) begin
            rdata_q <= {24'h0, rd_byte};
        end
    end

    // Non-synthesizer registers are lost while the chip sits in settle reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (rst || (busy && !REG_KEEP[i])) begin
                regs_q[i] <= REG_RESET[i];
            end else if (wr && slot == 5'(i)) begin
                regs_q[i] <= wb_dat_i[7:0] & REG_MASK[i];
            end
        end
    end

    // Settle sequencer; a request while settling is ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 32'h0;
                    if (rst_req) begin
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (cnt_q == 32'(SETTLE_CYCLES - 1)) begin
                        state_q <= ST_IDLE;
                        cnt_q <= 32'h0;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q <= 32'h0;
                end
            endcase
        end
    end

    // Front end controls, registered so every pin comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            input_a_power_down <= 4'h0;
            input_b_power_down <= 4'h0;
            pair_input_select <= 4'h0;
            conv_manual_gain_sel <= 2'h0;
            input_gain_value <= 32'h0;
            input_chroma_clamp <= 8'h0;
            input_clamp_value <= 32'h0;
            conv_bias_setting <= {REG_RESET[CONV_STRIDE + SLOT_BIAS][POS_BIAS +: 4],
                                  REG_RESET[SLOT_BIAS][POS_BIAS +: 4]};
        end else begin
            for (int c = 0; c < 2; c++) begin
                conv_manual_gain_sel[c] <= regs_q[c*CONV_STRIDE][POS_MANUAL_GAIN];
                conv_bias_setting[4*c +: 4] <= regs_q[c*CONV_STRIDE + SLOT_BIAS][POS_BIAS +: 4];
            end
            for (int p = 0; p < 4; p++) begin
                input_a_power_down[p] <= regs_q[(p/2)*CONV_STRIDE][POS_PAIR_PD + p%2];
                input_b_power_down[p] <= regs_q[(p/2)*CONV_STRIDE][POS_PAIR_PD + p%2];
                pair_input_select[p] <= regs_q[(p/2)*CONV_STRIDE][POS_INPUT_SEL + 2*(p%2)];
            end
            for (int i = 0; i < 8; i++) begin
                if (regs_q[(i/4)*CONV_STRIDE][POS_MANUAL_GAIN]) begin
                    input_gain_value[4*i +: 4] <=
                        regs_q[(i/4)*CONV_STRIDE + SLOT_GAIN + (i%4)/2][4*(i%2) +: 4];
                end else begin
                    input_gain_value[4*i +: 4] <= auto_gain[4*i +: 4];
                end
                input_chroma_clamp[i] <= regs_q[(i/4)*CONV_STRIDE + SLOT_BIAS][i%4];
                input_clamp_value[4*i +: 4] <=
                    regs_q[(i/4)*CONV_STRIDE + SLOT_CLAMP + (i%4)/2][4*(i%2) +: 4];
            end
        end
    end

    // Filter and clock delay selects
    always_ff @(posedge clk) begin
        if (rst) begin
            lpf_6mhz_en <= 2'h0;
            lpf_9mhz_en <= 2'h0;
            lpf_bypass <= 2'h0;
            clock_delay_sel <= 15'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                lpf_6mhz_en[c] <= (regs_q[SLOT_LPF][2*c +: 2] == LPF_6MHZ);
                lpf_9mhz_en[c] <= (regs_q[SLOT_LPF][2*c +: 2] == LPF_9MHZ);
                lpf_bypass[c] <= (regs_q[SLOT_LPF][2*c +: 2] != LPF_6MHZ) &&
                                 (regs_q[SLOT_LPF][2*c +: 2] != LPF_9MHZ);
            end
            // Steps of CLK_DELAY_STEP_PS
            clock_delay_sel <= {regs_q[SLOT_DLY_VD][2:0],
                                regs_q[SLOT_DLY_B][6:4], regs_q[SLOT_DLY_B][2:0],
                                regs_q[SLOT_DLY_A][6:4], regs_q[SLOT_DLY_A][2:0]};
        end
    end

    // Synthesizer settings; the analog macro computes XIN*(M+2)/((N+2)*OD*2)
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_multiplier <= {PLL2_DEF_M, PLL1_DEF_M};
            pll_predivider <= {PLL2_DEF_N, PLL1_DEF_N};
            pll_output_divider <= {PLL2_DEF_OD, PLL1_DEF_OD};
            pll_powerdown <= 2'h0;
            pll_bypass <= 2'h0;
            pll_output_enable_n <= 2'h0;
            pll_clock_source <= {CLKSRC_SYNTH, CLKSRC_SYNTH};
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (regs_q[SLOT_PLL_CTRL][k]) begin
                    pll_multiplier[WID_M*k +: WID_M] <=
                        {regs_q[SLOT_PLL1_M + 2*k + 1][POS_M_HIGH], regs_q[SLOT_PLL1_M + 2*k]};
                    pll_predivider[WID_N*k +: WID_N] <= regs_q[SLOT_PLL1_M + 2*k + 1][WID_N-1:0];
                    pll_output_divider[WID_OD*k +: WID_OD] <=
                        regs_q[SLOT_PLL_OD][POS_PLL_OD*k +: WID_OD];
                    pll_powerdown[k] <= regs_q[SLOT_PLL_PINS][POS_PLL_PD + 2*k];
                    pll_bypass[k] <= regs_q[SLOT_PLL_PINS][POS_PLL_BP + 2*k];
                    pll_output_enable_n[k] <= regs_q[SLOT_PLL_PINS][POS_PLL_OE + k];
                    if (regs_q[SLOT_PLL_PINS][POS_PLL_OE + k]) begin
                        pll_clock_source[2*k +: 2] <= CLKSRC_OFF;
                    end else if (regs_q[SLOT_PLL_PINS][POS_PLL_BP + 2*k]) begin
                        pll_clock_source[2*k +: 2] <= CLKSRC_XIN;
                    end else if (!regs_q[SLOT_PLL_PINS][POS_PLL_PD + 2*k]) begin
                        pll_clock_source[2*k +: 2] <= CLKSRC_SYNTH;
                    end else begin
                        pll_clock_source[2*k +: 2] <= CLKSRC_UNDEF;
                    end
                end else begin
                    pll_multiplier[WID_M*k +: WID_M] <= (k == 0) ? PLL1_DEF_M : PLL2_DEF_M;
                    pll_predivider[WID_N*k +: WID_N] <= (k == 0) ? PLL1_DEF_N : PLL2_DEF_N;
                    pll_output_divider[WID_OD*k +: WID_OD] <=
                        (k == 0) ? PLL1_DEF_OD : PLL2_DEF_OD;
                    pll_powerdown[k] <= 1'b0;
                    pll_bypass[k] <= 1'b0;
                    pll_output_enable_n[k] <= 1'b0;
                    pll_clock_source[2*k +: 2] <= CLKSRC_SYNTH;
                end
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign settle_reset = state_q[1];
endmodule

//--- verif/cfgbank_checker.sv
// Port assertions for the configuration bank
`timescale 1ns/1ns
module cfgbank_checker
    import cfgbank_pkg::*;
#(
    parameter int SETTLE_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Converter controls
    input wire logic [31:0] auto_gain,
    input wire logic [3:0] input_a_power_down,
    input wire logic [3:0] input_b_power_down,
    input wire logic [3:0] pair_input_select,
    input wire logic [1:0] conv_manual_gain_sel,
    input wire logic [31:0] input_gain_value,
    input wire logic [1:0] lpf_6mhz_en,
    input wire logic [1:0] lpf_9mhz_en,
    input wire logic [1:0] lpf_bypass,
    // Synthesizer controls
    input wire logic [1:0] pll_output_enable_n,
    input wire logic [3:0] pll_clock_source,
    input wire logic settle_reset
);
    logic take;
    logic wr_ok;
    logic [31:0] busy_cnt_q;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes to converter registers are lost while settling
    assign wr_ok = take && wb_we_i && wb_sel_i[0] && !settle_reset;
    always_ff @(posedge clk) begin
        if (rst || !settle_reset) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_bus_answer;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer wrong");
    property p_pair_power;
        wr_ok && wb_adr_i == 10'h200 |=> ##1 input_a_power_down[1:0] == $past(wb_dat_i[1:0], 2)
            && input_b_power_down[1:0] == $past(wb_dat_i[1:0], 2);
    endproperty
    a_pair_power: assert property (p_pair_power) else $error("pair power wrong");
    property p_input_sel;
        wr_ok && wb_adr_i == 10'h200 |=> ##1
            pair_input_select[1:0] == {$past(wb_dat_i[6], 2), $past(wb_dat_i[4], 2)};
    endproperty
    a_input_sel: assert property (p_input_sel) else $error("input select wrong");
    property p_auto_gain;
        !$past(rst) && !conv_manual_gain_sel[0] |->
            input_gain_value[15:0] == $past(auto_gain[15:0]);
    endproperty
    a_auto_gain: assert property (p_auto_gain) else $error("automatic gain wrong");
    property p_manual_gain;
        wr_ok && wb_adr_i == 10'h208 && conv_manual_gain_sel[0] |=> ##1
            input_gain_value[7:0] == $past(wb_dat_i[7:0], 2);
    endproperty
    a_manual_gain: assert property (p_manual_gain) else $error("manual gain wrong");
    property p_filter;
        wr_ok && wb_adr_i == 10'h230 |=> ##1
            lpf_6mhz_en[0] == ($past(wb_dat_i[1:0], 2) == LPF_6MHZ)
            && lpf_9mhz_en[0] == ($past(wb_dat_i[1:0], 2) == LPF_9MHZ)
            && lpf_bypass[0] == ($past(wb_dat_i[1:0], 2) > 2'h1);
    endproperty
    a_filter: assert property (p_filter) else $error("filter decode wrong");
    property p_synth_off;
        pll_output_enable_n[0] |-> pll_clock_source[1:0] == CLKSRC_OFF;
    endproperty
    a_synth_off: assert property (p_synth_off) else $error("synth source wrong");
    property p_settle_start;
        wr_ok && wb_adr_i == 10'h240 && wb_dat_i[7] |-> ##[1:2] settle_reset;
    endproperty
    a_settle_start: assert property (p_settle_start) else $error("settle late");
    property p_settle_len;
        $fell(settle_reset) |-> busy_cnt_q == SETTLE_CYCLES;
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle length wrong");
endmodule

bind video_adc_pll_config_bank cfgbank_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .auto_gain(auto_gain), .input_a_power_down(input_a_power_down),
    .input_b_power_down(input_b_power_down), .pair_input_select(pair_input_select),
    .conv_manual_gain_sel(conv_manual_gain_sel), .input_gain_value(input_gain_value),
    .lpf_6mhz_en(lpf_6mhz_en), .lpf_9mhz_en(lpf_9mhz_en), .lpf_bypass(lpf_bypass),
    .pll_output_enable_n(pll_output_enable_n), .pll_clock_source(pll_clock_source),
    .settle_reset(settle_reset)
);

//--- verif/testbench.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ns
module testbench;
    import cfgbank_pkg::*;
    localparam logic [7:0] MASK [23] = '{8'h57, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h57, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h77, 8'h77, 8'h07, 8'h03, 8'h3f, 8'hff, 8'h9f,
        8'hff, 8'h9f, 8'hff};
    logic clk, rst, cyc, stb, we, ack, settle;
    logic [9:0] adr;
    logic [3:0] sel, pd_a, pd_b, in_sel, psrc;
    logic [31:0] dat_w, dat_o, dat_r, auto_gain, gain, clampv;
    logic [1:0] man, l6, l9, lbyp, ppd, pbp, poe;
    logic [7:0] chroma, bias, pod, ev;
    logic [14:0] dly;
    logic [17:0] pm;
    logic [9:0] pn;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    int n;

    video_adc_pll_config_bank #(.SETTLE_CYCLES(16)) uut (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_o), .wb_ack_o(ack), .auto_gain(auto_gain),
        .input_a_power_down(pd_a), .input_b_power_down(pd_b), .pair_input_select(in_sel),
        .conv_manual_gain_sel(man), .input_gain_value(gain), .input_chroma_clamp(chroma),
        .input_clamp_value(clampv), .conv_bias_setting(bias), .lpf_6mhz_en(l6), .lpf_9mhz_en(l9),
        .lpf_bypass(lbyp), .clock_delay_sel(dly), .pll_multiplier(pm), .pll_predivider(pn),
        .pll_output_divider(pod), .pll_powerdown(ppd), .pll_bypass(pbp),
        .pll_output_enable_n(poe), .pll_clock_source(psrc), .settle_reset(settle)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] wd,
            input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat_w <= {24'h0, wd};
        // Wait for ack; the bench timeout ends this wait only if ack never comes
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        check("bus ack", 32'(ack), 32'h1);
        dat_r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        xfer(idx, 1'b1, wd, 4'hf);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        xfer(idx, 1'b0, 8'h00, 4'hf);
        check(what, dat_r, {24'h0, exp});
    endtask

    // Derived outputs lag the register by one clock
    task automatic settle_out();
        @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h0;
        sel = 4'h0;
        dat_w = 32'h0;
        auto_gain = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 23; i++) begin
            ev = (i == 1 || i == 7) ? 8'ha0 : 8'h00;
            rd_chk("reset value", 8'h80 + i[7:0], ev);
        end
        check("default multiplier", 32'(pm), {14'h0, 9'd20, 9'd62});
        check("default predivider", 32'(pn), 32'h4);
        check("default divider", 32'(pod), 32'h21);
        check("default source", 32'(psrc), 32'ha);
        check("bias", 32'(bias), 32'haa);
        $display("test reset values done");
        for (int i = 0; i < 23; i++) begin
            wr(8'h80 + i[7:0], (i == 16) ? 8'h03 : 8'hff);
        end
        for (int i = 0; i < 23; i++) begin
            ev = MASK[i] & ((i == 16) ? 8'h03 : 8'hff);
            rd_chk("read back", 8'h80 + i[7:0], ev);
        end
        wr(8'h97, 8'h5a);
        rd_chk("unmapped", 8'h97, 8'h00);
        rd_chk("unmapped", 8'h7f, 8'h00);
        xfer(8'h84, 1'b1, 8'h00, 4'he);
        rd_chk("lane disabled", 8'h84, 8'hff);
        settle_out();
        check("manual gain", gain, 32'hffffffff);
        check("chroma clamp", 32'(chroma), 32'hff);
        check("clamp value", clampv, 32'hffffffff);
        check("delays", 32'(dly), 32'h7fff);
        check("soft multiplier", 32'(pm), 32'h3ffff);
        check("off source", 32'(psrc), 32'h0);
        $display("test all ones done");
        @(posedge clk);
        auto_gain <= 32'h13579bdf;
        wr(8'h80, 8'h11);
        settle_out();
        check("power down a", 32'(pd_a), 32'hd);
        check("power down b", 32'(pd_b), 32'hd);
        check("input select", 32'(in_sel), 32'hd);
        check("auto gain", gain, 32'hffff9bdf);
        check("manual select", 32'(man), 32'h2);
        for (int c = 0; c < 4; c++) begin
            wr(8'h8c, {4'h0, c[1:0], c[1:0]});
            settle_out();
            ev = 8'({{2{c == 0}}, {2{c == 1}}, {2{c > 1}}});
            check("filter", 32'({l6, l9, lbyp}), 32'(ev));
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h8f, {5'h0, c[2:0]});
            settle_out();
            check("decoder delay", 32'(dly[14:12]), 32'(c));
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h91, {3'h0, c[2], 2'h0, c[1], c[0]});
            settle_out();
            ev = c[2] ? 8'h00 : c[0] ? 8'h01 : c[1] ? 8'h03 : 8'h02;
            check("truth table", 32'(psrc[1:0]), 32'(ev));
            check("pll pins", 32'({poe[0], ppd[0], pbp[0]}), 32'(c[2:0]));
        end
        wr(8'h90, 8'h02);
        settle_out();
        check("mixed multiplier", 32'(pm), {14'h0, 9'h1ff, 9'd62});
        check("mixed predivider", 32'(pn), {22'h0, 5'h1f, 5'd4});
        $display("test decodes done");
        wr(8'h90, 8'h81);
        rd_chk("busy flag", 8'h90, 8'h81);
        wr(8'h84, 8'h12);
        wr(8'h94, 8'h3e);
        n = 0;
        while (settle === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check("settle over", 32'(settle), 32'h0);
        rd_chk("cleared", 8'h84, 8'h00);
        rd_chk("cleared", 8'h80, 8'h00);
        rd_chk("kept", 8'h94, 8'h3e);
        rd_chk("kept", 8'h96, 8'hff);
        rd_chk("override", 8'h90, 8'h01);
        $display("test settle done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk("second reset", 8'h94, 8'h00);
        $display("test second reset done");
        // Second synthesizer differs from these values by default
        wr(8'h94, 8'h3e);
        wr(8'h95, 8'h04);
        wr(8'h96, 8'h10);
        wr(8'h91, 8'h00);
        wr(8'h90, 8'h02);
        settle_out();
        check("program multiplier", 32'(pm[17:9]), 32'h3e);
        check("program predivider", 32'(pn[9:5]), 32'h4);
        check("program divider", 32'(pod[7:4]), 32'h1);
        check("program source", 32'(psrc[3:2]), 32'(CLKSRC_SYNTH));
        $display("test synthesizer program done");
        summarize();
    end
endmodule
